// *** hdl/cfs_exec.sv ***
// Execution unit for frame push, byte store, soft debug break and sign-extend byte.
// Assumes a combinational register-file read port and a memory path that acks or faults each store.
//
// Overview of operation
// - Argument count from four-bit field: 0..3,11 zero; 4..7 one; 8..10 two; 12,13 three; 14 four.
// - Store argument registers from register four upward at sp+0, +4, +8, +12.
// - Static count from same field: 1,5,9,13 one; 2,6,10 two; 3,7 three; 11 four.
// - Static argument registers follow, seven downward, at successively lower words.
// - With link flag set, store register 31 at sp-4 after arguments, before statics.
// - Extra statics: register 30 only for count seven, then down to 18 from 23 (count six or seven) or from 17 plus count.
// - Then register 17 if second static flag, then 16 if first static flag.
// - Below sp, higher-numbered registers land at higher addresses; arguments sit above sp ascending.
// - Finally stack pointer becomes original minus eight times the 8-bit frame size.
// - Misaligned stack pointer with any store implied raises an address error.
// - Any fault during the push aborts it; reissue restarts the whole sequence.
// - Field code 1111 is reserved; no particular outcome guaranteed.
// - Short byte store adds zero-extended 5-bit offset to base, no alignment check.
// - Extended byte store adds sign-extended 16-bit offset assembled across both halves.
// - Soft break in debug state raises debug-mode exception with code 0x9.
// - Soft break outside debug state raises a debug breakpoint exception.
// - The six-bit code field of the soft break is ignored by hardware.
// - Sign-extend byte rewrites the register with its bits 7..0 extended; no exception.
// - Each push store checks its own word alignment before issuing the write.
module cfs_exec
(
	// Clock and reset
	input  wire logic                  clock,
	input  wire logic                  rst,
	// APB register port
	input  wire cfs_pkg::cfs_apb_req_s apb_req,
	output      cfs_pkg::cfs_apb_rsp_s apb_rsp,
	// Instruction issue
	input  wire logic                  issue_valid,
	input  wire logic                  issue_ext,
	input  wire logic [31:0]           issue_insn,
	output      logic                  issue_ready,
	// Register file
	output      logic [4:0]            rf_rd_addr,
	input  wire logic [31:0]           rf_rd_data,
	output      cfs_pkg::cfs_rf_wr_s   rf_wr,
	// Data memory path
	output      cfs_pkg::cfs_mem_req_s mem_out,
	input  wire logic                  mem_ack,
	input  wire logic                  mem_exc,
	// Exceptions
	output      logic                  exc_valid,
	output      cfs_pkg::cfs_cause_e   exc_cause,
	output      logic [4:0]            debug_exc_code
);
	import cfs_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		cfs_state_e    st;
		cfs_phase_e    ph;
		logic [2:0]    cnt;
		logic [31:0]   sp0;
		logic [31:0]   run;
		logic [31:0]   vaddr;
		logic          ra;
		logic          s0;
		logic          s1;
		logic [2:0]    xs;
		logic [2:0]    nargs;
		logic [2:0]    nstat;
		logic [7:0]    fsz;
		logic [4:0]    rsel;
		logic [2:0]    ctrl;
		cfs_cause_e    last_cause;
		cfs_apb_rsp_s  apb;
		logic          issue_ready;
		logic [4:0]    rf_rd_addr;
		cfs_rf_wr_s    rf_wr;
		cfs_mem_req_s  mem;
		logic          exc_valid;
		cfs_cause_e    exc_cause;
		logic [4:0]    debug_exc_code;
	} cfs_s;

	cfs_s s;
	cfs_s next_s;

	// ------------------------------------------------------------
	// Field decoders
	// ------------------------------------------------------------
	// Reserved code falls through to zero: outcome left open
	function automatic logic [2:0] arg_count(input logic [3:0] f);
		unique case (f)
			4'h4, 4'h5, 4'h6, 4'h7: arg_count = 3'd1;
			4'h8, 4'h9, 4'ha:       arg_count = 3'd2;
			4'hc, 4'hd:             arg_count = 3'd3;
			4'he:                   arg_count = 3'd4;
			default:                arg_count = 3'd0;
		endcase
	endfunction

	function automatic logic [2:0] stat_count(input logic [3:0] f);
		unique case (f)
			4'h1, 4'h5, 4'h9, 4'hd: stat_count = 3'd1;
			4'h2, 4'h6, 4'ha:       stat_count = 3'd2;
			4'h3, 4'h7:             stat_count = 3'd3;
			4'hb:                   stat_count = 3'd4;
			default:                stat_count = 3'd0;
		endcase
	endfunction

	// Instruction classes seen at issue
	logic [15:0] lo;
	logic [15:0] hi;
	logic        dec_save;
	logic        dec_sb;
	logic        dec_break;
	logic        dec_seb;
	logic        implied;
	logic [31:0] seb_val;

	assign lo        = issue_insn[15:0];
	assign hi        = issue_insn[31:16];
	assign dec_save  = issue_ext && hi[15:11] == OP_EXTEND && lo[15:11] == OP_I8
		&& lo[10:8] == FN_SAVE_RESTORE && lo[SAVE_BIT];
	assign dec_sb    = lo[15:11] == OP_STORE_BYTE && (!issue_ext || hi[15:11] == OP_EXTEND);
	assign dec_break = !issue_ext && lo[15:11] == OP_REG_REG && lo[4:0] == FN_SOFT_BREAK;
	assign dec_seb   = !issue_ext && lo[15:11] == OP_REG_REG && lo[4:0] == FN_CONVERT
		&& lo[7:5] == CVT_SIGN_BYTE;
	assign implied   = s.ra || s.s0 || s.s1 || s.xs != 3'd0 || s.nargs != 3'd0 || s.nstat != 3'd0;
	assign seb_val   = {{24{rf_rd_data[7]}}, rf_rd_data[7:0]};

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	// Push picker scratch
	logic        has;
	logic [4:0]  preg;
	logic [31:0] paddr;
	logic [2:0]  xs_top;
	logic [2:0]  xs_j;
	logic [1:0]  bsel;

	always_comb
	begin
		next_s = s;
		next_s.rf_wr.en   = 1'b0;
		next_s.exc_valid  = 1'b0;
		next_s.apb.pready = 1'b0;
		next_s.apb.pslverr = 1'b0;
		has    = 1'b0;
		preg   = '0;
		paddr  = s.run - 32'd4;
		xs_top = (s.xs == 3'd7) ? 3'd6 : s.xs;
		xs_j   = s.cnt - ((s.xs == 3'd7) ? 3'd1 : 3'd0);
		bsel   = s.vaddr[1:0] ^ {2{s.ctrl[CTRL_BIG_BIT]}};

		// APB slave: one access cycle, answer prepared at setup
		if (apb_req.psel && !apb_req.penable && !s.apb.pready)
		begin
			next_s.apb.pready = 1'b1;
			if (apb_req.paddr == OFS_CTRL)
				next_s.apb.prdata = {29'h0, s.ctrl};
			else if (apb_req.paddr == OFS_STATUS)
				next_s.apb.prdata = {19'h0, s.debug_exc_code, 1'b0, s.last_cause, 3'h0, s.st != ST_IDLE};
			else
			begin
				next_s.apb.prdata  = 32'h0;
				next_s.apb.pslverr = 1'b1;
			end
		end
		if (apb_req.psel && apb_req.penable && s.apb.pready && apb_req.pwrite && apb_req.paddr == OFS_CTRL)
			next_s.ctrl = apb_req.pwdata[2:0];

		unique case (s.st)
			ST_IDLE:
			begin
				if (issue_valid)
				begin
					if (dec_save)
					begin
						next_s.ra    = lo[LINK_BIT];
						next_s.s0    = lo[S0_BIT];
						next_s.s1    = lo[S1_BIT];
						next_s.xs    = hi[XS_LSB +: 3];
						next_s.nargs = arg_count(hi[AREGS_LSB +: 4]);
						next_s.nstat = stat_count(hi[AREGS_LSB +: 4]);
						next_s.fsz   = {hi[FSH_LSB +: 4], lo[3:0]};
						next_s.rf_rd_addr = REG_SP;
						next_s.st    = ST_PUSH_SP;
					end
					else if (dec_sb)
					begin
						// Offset parked in vaddr until the base is read
						if (issue_ext)
							next_s.vaddr = {{16{hi[4]}}, hi[4:0], hi[10:5], lo[4:0]};
						else
							next_s.vaddr = {27'h0, lo[4:0]};
						next_s.rf_rd_addr = xlat(lo[10:8]);
						next_s.rsel  = xlat(lo[7:5]);
						next_s.st    = ST_SB_BASE;
					end
					else if (dec_break)
					begin
						// Code field bits 10..5 never looked at
						next_s.exc_valid = 1'b1;
						if (s.ctrl[CTRL_DBG_BIT])
						begin
							next_s.exc_cause      = CAUSE_DBG_MODE_BP;
							next_s.debug_exc_code = DEBUG_CODE_BP;
						end
						else
							next_s.exc_cause = CAUSE_DBG_BP;
						next_s.last_cause = next_s.exc_cause;
					end
					else if (dec_seb)
					begin
						next_s.rf_rd_addr = xlat(lo[10:8]);
						next_s.rsel  = xlat(lo[10:8]);
						next_s.st    = ST_SEB;
					end
				end
			end
			ST_PUSH_SP:
			begin
				next_s.sp0 = rf_rd_data;
				next_s.run = rf_rd_data;
				next_s.ph  = PH_ARGS;
				next_s.cnt = 3'd0;
				if (rf_rd_data[1:0] != 2'b00 && implied)
				begin
					next_s.exc_valid  = 1'b1;
					next_s.exc_cause  = CAUSE_ADDR;
					next_s.last_cause = CAUSE_ADDR;
					next_s.st = ST_IDLE;
				end
				else
					next_s.st = ST_PICK;
			end
			ST_PICK:
			begin
				// Argument phase walks upward from sp; later phases walk downward from the link slot
				unique case (s.ph)
					PH_ARGS:
					begin
						has   = s.cnt < s.nargs;
						preg  = REG_ARG0 + {2'b00, s.cnt};
						paddr = s.sp0 + {27'h0, s.cnt, 2'b00};
					end
					PH_LINK:
					begin
						has  = s.ra && s.cnt == 3'd0;
						preg = REG_LINK;
					end
					PH_XS:
					begin
						has  = s.cnt < s.xs;
						preg = (s.xs == 3'd7 && s.cnt == 3'd0) ? REG_XS_TOP
							: 5'(REG_XS_BASE + {2'b00, xs_top} - 5'd1 - {2'b00, xs_j});
					end
					PH_S1:
					begin
						has  = s.s1 && s.cnt == 3'd0;
						preg = REG_S1;
					end
					PH_S0:
					begin
						has  = s.s0 && s.cnt == 3'd0;
						preg = REG_S0;
					end
					PH_STAT:
					begin
						has  = s.cnt < s.nstat;
						preg = REG_ARG3 - {2'b00, s.cnt};
					end
				endcase
				if (has)
				begin
					next_s.rf_rd_addr = preg;
					next_s.vaddr = paddr;
					next_s.cnt   = s.cnt + 3'd1;
					if (s.ph != PH_ARGS)
						next_s.run = paddr;
					if (paddr[1:0] != 2'b00)
					begin
						next_s.exc_valid  = 1'b1;
						next_s.exc_cause  = CAUSE_ADDR;
						next_s.last_cause = CAUSE_ADDR;
						next_s.st = ST_IDLE;
					end
					else
						next_s.st = ST_PUSH_DATA;
				end
				else
				begin
					next_s.cnt = 3'd0;
					unique case (s.ph)
						PH_ARGS: next_s.ph = PH_LINK;
						PH_LINK: next_s.ph = PH_XS;
						PH_XS:   next_s.ph = PH_S1;
						PH_S1:   next_s.ph = PH_S0;
						PH_S0:   next_s.ph = PH_STAT;
						PH_STAT: next_s.st = ST_FIN;
					endcase
				end
			end
			ST_PUSH_DATA:
			begin
				next_s.mem = '{req: 1'b1, word: 1'b1, addr: s.vaddr, data: rf_rd_data, be: 4'hf};
				next_s.st  = ST_WAIT;
			end
			ST_WAIT:
			begin
				// The stack pointer is not written before the end, so abort is a clean restart
				if (mem_exc)
				begin
					next_s.mem.req    = 1'b0;
					next_s.exc_valid  = 1'b1;
					next_s.exc_cause  = CAUSE_MEM;
					next_s.last_cause = CAUSE_MEM;
					next_s.st = ST_IDLE;
				end
				else if (mem_ack)
				begin
					next_s.mem.req = 1'b0;
					next_s.st = s.mem.word ? ST_PICK : ST_IDLE;
				end
			end
			ST_FIN:
			begin
				// Independent of the running store address
				next_s.rf_wr = '{en: 1'b1, addr: REG_SP, data: s.sp0 - {21'h0, s.fsz, 3'b000}};
				next_s.st = ST_IDLE;
			end
			ST_SB_BASE:
			begin
				next_s.vaddr = s.vaddr + rf_rd_data;
				next_s.rf_rd_addr = s.rsel;
				next_s.st = ST_SB_DATA;
			end
			ST_SB_DATA:
			begin
				// Lane from endian-adjusted select; no alignment check for bytes
				next_s.mem.req  = 1'b1;
				next_s.mem.word = 1'b0;
				next_s.mem.addr = {s.vaddr[31:2], s.vaddr[1:0] ^ {2{s.ctrl[CTRL_REV_BIT]}}};
				next_s.mem.data = {24'h0, rf_rd_data[7:0]} << {bsel, 3'b000};
				next_s.mem.be   = 4'b0001 << bsel;
				next_s.st = ST_WAIT;
			end
			ST_SEB:
			begin
				next_s.rf_wr = '{en: 1'b1, addr: s.rsel, data: seb_val};
				next_s.st = ST_IDLE;
			end
			default:
				next_s.st = ST_IDLE;
		endcase
		next_s.issue_ready = next_s.st == ST_IDLE;
	end

	// State register
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			s <= '0;
			s.ctrl <= CTRL_RESET;
			s.issue_ready <= 1'b1;
		end
		else
			s <= next_s;
	end

	// Outputs straight from the state register
	assign apb_rsp        = s.apb;
	assign issue_ready    = s.issue_ready;
	assign rf_rd_addr     = s.rf_rd_addr;
	assign rf_wr          = s.rf_wr;
	assign mem_out        = s.mem;
	assign exc_valid      = s.exc_valid;
	assign exc_cause      = s.exc_cause;
	assign debug_exc_code = s.debug_exc_code;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	sequence push_store_s;
		$rose(s.mem.req) && s.mem.word;
	endsequence

	sequence down_step_s;
		s.st == ST_PICK && s.ph != PH_ARGS ##1 s.st == ST_PUSH_DATA;
	endsequence

	sequence sp_bad_s;
		s.st == ST_PUSH_SP && rf_rd_data[1:0] != 2'b00 && implied;
	endsequence

	arg_addr_a: assert property (push_store_s and s.ph == PH_ARGS |->
		s.mem.addr == s.sp0 + {27'h0, 3'(s.cnt - 3'd1), 2'b00})
		else $error("argument store at wrong address");
	link_store_a: assert property (push_store_s and s.ph == PH_LINK |->
		s.rf_rd_addr == REG_LINK && s.mem.addr == s.sp0 - 32'd4)
		else $error("link store wrong register or address");
	down_step_a: assert property (down_step_s |-> s.run == $past(s.run, 2) - 32'd4)
		else $error("push store not one word lower");
	frame_sp_a: assert property (s.rf_wr.en && s.rf_wr.addr == REG_SP |->
		s.rf_wr.data == s.sp0 - {21'h0, s.fsz, 3'b000})
		else $error("final stack pointer wrong");
	sp_align_a: assert property (sp_bad_s |=> s.exc_valid && s.exc_cause == CAUSE_ADDR
		&& s.st == ST_IDLE && !s.mem.req)
		else $error("misaligned stack pointer not trapped");
	fault_restart_a: assert property (s.st == ST_WAIT && mem_exc |=> s.st == ST_IDLE
		&& !s.mem.req ##1 !s.rf_wr.en)
		else $error("push not aborted on fault");
	sb_base_a: assert property (s.st == ST_SB_BASE |=>
		s.vaddr == $past(s.vaddr) + $past(rf_rd_data) ##1 s.mem.req && !s.mem.word)
		else $error("byte store address wrong");
	mode_code_a: assert property (s.exc_valid && s.exc_cause == CAUSE_DBG_MODE_BP |->
		s.debug_exc_code == DEBUG_CODE_BP && $past(s.ctrl[CTRL_DBG_BIT]))
		else $error("debug mode break code wrong");
	seb_ext_a: assert property (s.st == ST_SEB |=> s.rf_wr.en && s.rf_wr.data == $past(seb_val)
		&& !s.exc_valid)
		else $error("sign extend result wrong");
	byte_lane_a: assert property ($rose(s.mem.req) && !s.mem.word |-> s.mem.be == 4'b0001 <<
		(s.mem.addr[1:0] ^ {2{s.ctrl[CTRL_REV_BIT]}} ^ {2{s.ctrl[CTRL_BIG_BIT]}}))
		else $error("byte lane wrong");
	mem_hold_a: assert property (s.mem.req && !mem_ack && !mem_exc |=> s.mem.req && $stable(s.mem.addr))
		else $error("memory request dropped early");

endmodule

// *** hdl/cfs_pkg.sv ***
// Shared constants and carrier types for the compact frame save / byte store execution block.
// Assumes a single core clock; translation and the register file live outside the block.
package cfs_pkg;

	// ------------------------------------------------------------
	// Opcode and function encodings
	// ------------------------------------------------------------
	localparam logic [4:0] OP_EXTEND        = 5'h1e;
	localparam logic [4:0] OP_STORE_BYTE    = 5'h18;
	localparam logic [4:0] OP_REG_REG       = 5'h1d;
	localparam logic [4:0] OP_I8            = 5'h0c;
	localparam logic [2:0] FN_SAVE_RESTORE  = 3'h4;
	localparam logic [4:0] FN_SOFT_BREAK    = 5'h01;
	localparam logic [4:0] FN_CONVERT       = 5'h11;
	localparam logic [2:0] CVT_SIGN_BYTE    = 3'h4;
	localparam logic [3:0] ARGS_RESERVED    = 4'hf;

	// ------------------------------------------------------------
	// Field positions (low half and extend half)
	// ------------------------------------------------------------
	localparam int unsigned SAVE_BIT        = 7;
	localparam int unsigned LINK_BIT        = 6;
	localparam int unsigned S0_BIT          = 5;
	localparam int unsigned S1_BIT          = 4;
	localparam int unsigned XS_LSB          = 8;
	localparam int unsigned FSH_LSB         = 4;
	localparam int unsigned AREGS_LSB       = 0;

	// ------------------------------------------------------------
	// Register numbers and codes
	// ------------------------------------------------------------
	localparam logic [4:0] REG_SP           = 5'h1d;
	localparam logic [4:0] REG_LINK         = 5'h1f;
	localparam logic [4:0] REG_XS_TOP       = 5'h1e;
	localparam logic [4:0] REG_XS_BASE      = 5'h12;
	localparam logic [4:0] REG_S1           = 5'h11;
	localparam logic [4:0] REG_S0           = 5'h10;
	localparam logic [4:0] REG_ARG0         = 5'h04;
	localparam logic [4:0] REG_ARG3         = 5'h07;
	localparam logic [4:0] DEBUG_CODE_BP    = 5'h09;

	// ------------------------------------------------------------
	// APB register map
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL         = 8'h00;
	localparam logic [7:0] OFS_STATUS       = 8'h04;
	localparam int unsigned CTRL_BIG_BIT    = 0;
	localparam int unsigned CTRL_REV_BIT    = 1;
	localparam int unsigned CTRL_DBG_BIT    = 2;
	localparam logic [2:0] CTRL_RESET       = 3'h0;
	localparam int unsigned STAT_CAUSE_LSB  = 4;
	localparam int unsigned STAT_DBG_LSB    = 8;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {ST_IDLE, ST_PUSH_SP, ST_PICK, ST_PUSH_DATA, ST_WAIT, ST_FIN,
		ST_SB_BASE, ST_SB_DATA, ST_SEB} cfs_state_e;
	typedef enum logic [2:0] {PH_ARGS, PH_LINK, PH_XS, PH_S1, PH_S0, PH_STAT} cfs_phase_e;
	typedef enum logic [2:0] {CAUSE_NONE, CAUSE_ADDR, CAUSE_MEM, CAUSE_DBG_BP, CAUSE_DBG_MODE_BP} cfs_cause_e;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} cfs_apb_req_s;

	typedef struct packed {
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} cfs_apb_rsp_s;

	typedef struct packed {
		logic        req;
		logic        word;
		logic [31:0] addr;
		logic [31:0] data;
		logic [3:0]  be;
	} cfs_mem_req_s;

	typedef struct packed {
		logic        en;
		logic [4:0]  addr;
		logic [31:0] data;
	} cfs_rf_wr_s;

	// Three-bit register code to full register number
	function automatic logic [4:0] xlat(input logic [2:0] code);
		xlat = (code < 3'd2) ? (REG_S0 + {2'b00, code}) : {2'b00, code};
	endfunction

endpackage

// *** testbench/cfs_exec_tb.sv ***
// Self-checking bench for the frame push / byte store execution block.
// Assumes the memory model beside it; the register file is kept here.
module cfs_exec_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import cfs_pkg::*;
	logic          clock = 1'b0;
	logic          rst = 1'b1;
	cfs_apb_req_s  apb_req = '0;
	cfs_apb_rsp_s  apb_rsp;
	logic          issue_valid = 1'b0;
	logic          issue_ext = 1'b0;
	logic [31:0]   issue_insn = '0;
	logic          issue_ready;
	logic [4:0]    rf_rd_addr;
	logic [31:0]   rf_rd_data;
	cfs_rf_wr_s    rf_wr;
	cfs_mem_req_s  mem_out;
	logic          mem_ack;
	logic          mem_exc;
	logic          exc_valid;
	cfs_cause_e    exc_cause;
	logic [4:0]    debug_exc_code;
	logic [1:0]    lat = 2'h0;
	logic          fault_arm = 1'b0;
	logic [3:0]    fault_idx = 4'h0;
	int            failures = 0;
	int            checks_done = 0;
	int            exc_n;
	int            wr_n;
	logic [31:0]   regs [32];
	logic [31:0]   t_run;
	logic [31:0]   got_a[$], got_d[$], exp_a[$], exp_d[$];
	logic [3:0]    got_be[$];
	cfs_cause_e    last_cause;
	cfs_rf_wr_s    last_wr;

	cfs_exec cfs_exec_i (.clock(clock), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
		.issue_valid(issue_valid), .issue_ext(issue_ext), .issue_insn(issue_insn),
		.issue_ready(issue_ready), .rf_rd_addr(rf_rd_addr), .rf_rd_data(rf_rd_data), .rf_wr(rf_wr),
		.mem_out(mem_out), .mem_ack(mem_ack), .mem_exc(mem_exc), .exc_valid(exc_valid),
		.exc_cause(exc_cause), .debug_exc_code(debug_exc_code));
	cfs_mem_model cfs_mem_model_i (.clock(clock), .rst(rst), .mem_out(mem_out), .mem_ack(mem_ack),
		.mem_exc(mem_exc), .lat(lat), .fault_arm(fault_arm), .fault_idx(fault_idx));

	// Register file: combinational read, writes land at the edge
	assign rf_rd_data = regs[rf_rd_addr];
	always @(posedge clock)
	begin
		if (mem_out.req && mem_ack)
		begin
			got_a.push_back(mem_out.addr);
			got_d.push_back(mem_out.data);
			got_be.push_back(mem_out.be);
		end
		if (exc_valid)
		begin
			exc_n++;
			last_cause = exc_cause;
		end
		if (rf_wr.en)
		begin
			wr_n++;
			last_wr = rf_wr;
			regs[rf_wr.addr] <= rf_wr.data;
		end
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
		checks_done++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic summarize();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Offer one instruction, wait for take and completion
	task automatic issue(input logic ext, input logic [31:0] insn);
		int n;
		got_a.delete(); got_d.delete(); got_be.delete();
		exc_n = 0;
		wr_n = 0;
		n = 0;
		issue_ext <= ext;
		issue_insn <= insn;
		issue_valid <= 1'b1;
		do @(posedge clock); while (issue_ready !== 1'b1);
		issue_valid <= 1'b0;
		repeat (3) @(posedge clock);
		while (issue_ready !== 1'b1 && n < 300)
		begin
			@(posedge clock);
			n++;
		end
		repeat (2) @(posedge clock);
		chk(n < 300, 1'b1, "issue done");
	endtask

	// APB master: setup, then access until pready sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge clock);
		apb_req.penable <= 1'b1;
		do @(posedge clock); while (apb_rsp.pready !== 1'b1);
		q = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req <= '0;
		// One idle edge, so a following call never re-drives psel in this step
		@(posedge clock);
	endtask

	task automatic add(input logic [31:0] d);
		t_run -= 32'h4;
		exp_a.push_back(t_run);
		exp_d.push_back(d);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_push(input logic [3:0] ar, input logic ra, s0, s1, input logic [2:0] xs,
		input logic [7:0] fs, input logic [3:0] fidx);
		logic [31:0] sp;
		int na, ns;
		sp = regs[29];
		t_run = sp;
		na = ar inside {4, 5, 6, 7} ? 1 : ar inside {8, 9, 10} ? 2 : ar inside {12, 13} ? 3 : ar == 14 ? 4 : 0;
		ns = ar inside {1, 5, 9, 13} ? 1 : ar inside {2, 6, 10} ? 2 : ar inside {3, 7} ? 3 : ar == 11 ? 4 : 0;
		exp_a.delete(); exp_d.delete();
		for (int i = 0; i < na; i++)
		begin
			exp_a.push_back(sp + 32'(4 * i));
			exp_d.push_back(regs[4 + i]);
		end
		if (ra) add(regs[31]);
		if (xs > 6) add(regs[30]);
		for (int i = (xs > 6 ? 6 : int'(xs)); i > 0; i--) add(regs[17 + i]);
		if (s1) add(regs[17]);
		if (s0) add(regs[16]);
		for (int i = 0; i < ns; i++) add(regs[7 - i]);
		// A fault part-way leaves the frame half written; the reissue redoes it all
		fault_arm <= fidx != 4'h0;
		fault_idx <= fidx;
		if (fidx != 4'h0)
		begin
			issue(1'b1, {OP_EXTEND, xs, fs[7:4], ar, OP_I8, FN_SAVE_RESTORE, 1'b1, ra, s0, s1, fs[3:0]});
			chk(got_a.size(), 32'(fidx - 4'h1), "stores before fault");
			chk(32'(last_cause) + wr_n, 32'(CAUSE_MEM), "fault abort");
			fault_arm <= 1'b0;
		end
		issue(1'b1, {OP_EXTEND, xs, fs[7:4], ar, OP_I8, FN_SAVE_RESTORE, 1'b1, ra, s0, s1, fs[3:0]});
		chk(got_a.size(), exp_a.size(), "push count");
		foreach (exp_a[i])
		begin
			if (i < got_a.size())
			begin
				chk(got_a[i], exp_a[i], "push addr");
				chk(got_d[i], exp_d[i], "push data");
				chk(got_be[i], 4'hf, "push word lanes");
			end
		end
		chk({wr_n, 27'h0, last_wr.addr}, {32'h1, 32'h1d}, "sp write");
		chk(last_wr.data, sp - {24'h0, fs, 3'h0}, "sp value");
	endtask

	task automatic t_mis(input logic [3:0] ar, input logic ra, input logic [2:0] xs, input logic err);
		regs[29] = 32'h0000_8002;
		issue(1'b1, {OP_EXTEND, xs, 4'h0, ar, OP_I8, FN_SAVE_RESTORE, 1'b1, ra, 2'h0, 4'h4});
		chk(got_a.size(), 0, "misaligned stores");
		chk(exc_n, err, "misaligned exc");
		if (err) chk(32'(last_cause), 32'(CAUSE_ADDR), "misaligned cause");
		else chk(regs[29], 32'h0000_7fe2, "unaligned sp ok");
		regs[29] = 32'h0000_8000;
	endtask

	task automatic t_sb(input logic big, rev, ext, input logic [15:0] off);
		logic [31:0] q, va;
		logic e;
		logic [1:0] ln;
		apb(1'b1, OFS_CTRL, {30'h0, rev, big}, q, e);
		regs[16] = 32'h0000_1003;
		regs[5] = 32'h1234_56a5;
		va = regs[16] + (ext ? {{16{off[15]}}, off} : {27'h0, off[4:0]});
		ln = va[1:0] ^ {2{big}};
		issue(ext, {OP_EXTEND, off[10:5], off[15:11], OP_STORE_BYTE, 3'h0, 3'h5, off[4:0]});
		chk(got_a.size() + exc_n, 1, "sb once, no fault");
		chk(got_a[0], {va[31:2], va[1:0] ^ {2{rev}}}, "sb addr");
		chk(got_be[0], 4'h1 << ln, "sb lane");
		chk((got_d[0] >> (8 * ln)) & 32'hff, 32'ha5, "sb byte");
	endtask

	task automatic t_brk(input logic dm, input logic [5:0] code);
		logic [31:0] q;
		logic e;
		apb(1'b1, OFS_CTRL, {29'h0, dm, 2'h0}, q, e);
		issue(1'b0, {16'h0, OP_REG_REG, code, FN_SOFT_BREAK});
		chk(exc_n + got_a.size() + wr_n, 1, "break exc only");
		chk(32'(last_cause), dm ? 32'(CAUSE_DBG_MODE_BP) : 32'(CAUSE_DBG_BP), "break cause");
		apb(1'b0, OFS_STATUS, 32'h0, q, e);
		if (dm) chk(32'(q[12:8]), 32'h9, "break code");
		if (dm) chk(32'(debug_exc_code), 32'h9, "break code port");
	endtask

	task automatic t_seb(input logic [2:0] c, input logic [31:0] v);
		logic [4:0] r;
		r = c < 3'h2 ? 5'h10 + {2'h0, c} : {2'h0, c};
		regs[r] = v;
		issue(1'b0, {16'h0, OP_REG_REG, c, CVT_SIGN_BYTE, FN_CONVERT});
		chk({wr_n, exc_n}, {32'h1, 32'h0}, "seb one write");
		chk({27'h0, last_wr.addr}, {27'h0, r}, "seb reg");
		chk(last_wr.data, {{24{v[7]}}, v[7:0]}, "seb value");
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial forever #50 clock = ~clock;

	initial
	begin
		logic [31:0] q;
		logic e;
		for (int i = 0; i < 32; i++) regs[i] = 32'h5a00_0000 | 32'(i * 257);
		regs[29] = 32'h0000_8000;
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		apb(1'b0, OFS_CTRL, 32'h0, q, e);
		chk({q, 31'h0, e}, 64'h0, "ctrl reset");
		apb(1'b0, 8'h08, 32'h0, q, e);
		chk(e, 1'b1, "unmapped refused");
		for (int a = 0; a < 15; a++)
		begin
			lat <= 2'(a % 3);
			regs[29] = 32'h0000_8000;
			t_push(4'(a), a[0], a[1], a[2], 3'(a), 8'(a * 37), a == 14 ? 4'h3 : a == 7 ? 4'h1 : 4'h0);
		end
		t_mis(4'h0, 1'b1, 3'h0, 1'b1);
		t_mis(4'hb, 1'b0, 3'h0, 1'b1);
		t_mis(4'h0, 1'b0, 3'h2, 1'b1);
		t_mis(4'h0, 1'b0, 3'h0, 1'b0);
		t_sb(1'b0, 1'b0, 1'b0, 16'h001f);
		t_sb(1'b1, 1'b0, 1'b0, 16'h0002);
		t_sb(1'b0, 1'b1, 1'b1, 16'hfff3);
		t_sb(1'b1, 1'b1, 1'b1, 16'h7ffe);
		t_brk(1'b0, 6'h00);
		t_brk(1'b1, 6'h3f);
		t_seb(3'h6, 32'h1234_5680);
		t_seb(3'h1, 32'h0000_007f);
		summarize();
	end

	// Watchdog: the whole run needs well under 20000 cycles
	initial
	begin
		#2ms;
		failures++;
		$display("ERROR %0t watchdog expired", $time);
		summarize();
	end
endmodule

// *** testbench/cfs_mem_model.sv ***
// Data memory path model: answers each store after a set wait.
// Assumes the request stands until an ack or fault has been seen.
module cfs_mem_model
	import cfs_pkg::*;
(
	// Clock and reset
	input  wire logic                  clock,
	input  wire logic                  rst,
	// Store request and answer
	input  wire cfs_pkg::cfs_mem_req_s mem_out,
	output      logic                  mem_ack,
	output      logic                  mem_exc,
	// Behaviour control
	input  wire logic [1:0]            lat,
	input  wire logic                  fault_arm,
	input  wire logic [3:0]            fault_idx
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] wait_cnt;
	logic [3:0] served;
	logic       answered;
	// One answer per request; answered blocks a second pulse while req falls
	always_ff @(posedge clock)
	begin
		mem_ack <= 1'b0;
		mem_exc <= 1'b0;
		if (rst || !mem_out.req)
		begin
			wait_cnt <= 2'h0;
			answered <= 1'b0;
		end
		else if (!answered && wait_cnt == lat)
		begin
			answered <= 1'b1;
			served <= served + 4'h1;
			if (fault_arm && served + 4'h1 == fault_idx)
				mem_exc <= 1'b1;
			else
				mem_ack <= 1'b1;
		end
		else if (!answered)
			wait_cnt <= wait_cnt + 2'h1;
		if (rst || !fault_arm)
			served <= 4'h0;
	end
endmodule
